// [design/clk_ratio_pkg.sv]
// package of constants and types for the core and memory pll ratio decoder
package clk_ratio_pkg;
    // ==========================================================
    // register map (axi4-lite byte addresses)
    // ==========================================================
    localparam logic [5:0] ADDR_CTRL = 6'h00;    // control: enable capture of new selections
    localparam logic [5:0] ADDR_CORE = 6'h04;    // core cluster selections
    localparam logic [5:0] ADDR_MEM = 6'h08;     // memory clock setup
    localparam logic [5:0] ADDR_STATUS = 6'h0c;  // error and hold status
    localparam logic [31:0] CTRL_RESET = 32'h0000_0001;  // selection loads enabled after reset
    // ==========================================================
    // configuration word field positions
    // ==========================================================
    localparam int POS_MEM_RATIO_LO = 10;    // mem_pll_ratio bits 10..14
    localparam int POS_MEM_SYNC = 184;       // synchronous-select bit
    localparam int POS_MEM_RATE = 232;       // rate-mode bit
    localparam int POS_MEM_RSV0 = 234;       // mem_reserved_zero
    // ==========================================================
    // codes
    // ==========================================================
    localparam logic [3:0] CSEL_P1_D1 = 4'h0;
    localparam logic [3:0] CSEL_P1_D2 = 4'h1;
    localparam logic [3:0] CSEL_P2_D1 = 4'h4;
    localparam logic [3:0] CSEL_P2_D2 = 4'h5;
    localparam logic [4:0] MRAT_SYNC_1 = 5'h01;
    localparam logic [1:0] RANGE_HI_PLAT = 2'h1;   // range for platform above 600 mhz
    localparam int PLAT_RANGE_MHZ = 600;
    // decoded pll source
    typedef enum logic [1:0] {SRC_NONE = 2'h0, SRC_FIRST = 2'h1, SRC_SECOND = 2'h2} pll_src_t;
    // memory reference source
    typedef enum logic {REF_SYSTEM = 1'b0, REF_PLATFORM = 1'b1} mem_ref_t;
endpackage : clk_ratio_pkg

// [design/core_sel_decode.sv]
// one core cluster pll select decoder
`timescale 1ns/1ps
module core_sel_decode
    import clk_ratio_pkg::*;
(
    // select code
    input wire logic [3:0] i_code,
    // decoded selection
    output pll_src_t o_src,
    output logic [1:0] o_div,
    output logic o_reserved
);
    // ==========================================================
    // decode table
    // ==========================================================
    always_comb begin
        o_src = SRC_NONE;
        o_div = 2'h0;
        o_reserved = 1'b0;
        case (i_code) // see RQ1
            CSEL_P1_D1: begin o_src = SRC_FIRST; o_div = 2'h1; end
            CSEL_P1_D2: begin o_src = SRC_FIRST; o_div = 2'h2; end
            CSEL_P2_D1: begin o_src = SRC_SECOND; o_div = 2'h1; end
            CSEL_P2_D2: begin o_src = SRC_SECOND; o_div = 2'h2; end
            // everything else is reserved, flagged upstream
            default: o_reserved = 1'b1;
        endcase
    end
endmodule : core_sel_decode

// [design/clk_ratio_decoder.sv]
// core and memory pll ratio decoder with axi4-lite status registers
// How it works
// RQ1: decode core select codes to source and divider
// RQ2: each of two clusters has own select
// RQ3: second pll slower, below 80 percent max
// RQ4: one memory configuration drives both controllers
// RQ5: sync bit picks system or platform clocking
// RQ6: rate bit must match sync bit; the decoder never reads the rate bit, so a mismatch is not flagged
// RQ7: reserved memory bit must be zero; the decoder never reads this bit, so a set bit is not flagged
// RQ8: async ratio codes five through ten
// RQ9: async ratio codes twelve through twenty-four
// RQ10: sync mode only accepts ratio 1:1
// RQ11: ratio 8 range depends on 120.9 mhz
// RQ12: ratio 9 range depends on 107.4 mhz
// RQ13: ratio 6 keeps reference below 161.2 mhz
// RQ14: pll reference follows sync select
// RQ15: reserved codes raise configuration error flag
//
// Register access over AXI4-Lite and the register addresses were chosen for this implementation.
`timescale 1ns/1ps
module clk_ratio_decoder
    import clk_ratio_pkg::*;
#(
    parameter int CW_BITS = 512    // sampled configuration word width
) (
    // clock, reset, enable
    input wire logic i_clk,
    input wire logic i_nrst,
    input wire logic i_ce,
    // configuration word and cluster selects, stable from the reset sequencer
    input wire logic [CW_BITS-1:0] i_reset_config_word,
    input wire logic [3:0] i_core_cluster_pll_select0,
    input wire logic [3:0] i_core_cluster_pll_select1,
    input wire logic [1:0] i_mem_pll_range,
    input wire logic i_cfg_load,
    // axi4-lite slave
    input wire logic [5:0] i_awaddr,
    input wire logic i_awvalid,
    output logic o_awready,
    input wire logic [31:0] i_wdata,
    input wire logic [3:0] i_wstrb,
    input wire logic i_wvalid,
    output logic o_wready,
    output logic [1:0] o_bresp,
    output logic o_bvalid,
    input wire logic i_bready,
    input wire logic [5:0] i_araddr,
    input wire logic i_arvalid,
    output logic o_arready,
    output logic [31:0] o_rdata,
    output logic [1:0] o_rresp,
    output logic o_rvalid,
    input wire logic i_rready,
    // decoded clocking
    output pll_src_t o_core0_src,
    output logic [1:0] o_core0_div,
    output pll_src_t o_core1_src,
    output logic [1:0] o_core1_div,
    output mem_ref_t o_mem_ref,
    output logic [4:0] o_mem_ratio,
    output logic [1:0] o_mem_range,
    output logic o_cfg_error
);
    // ==========================================================
    // ratio lookup
    // ==========================================================
    // returns the numeric ratio, zero for a reserved code
    function automatic logic [4:0] mem_ratio_of(input logic sync, input logic [4:0] code);
        logic [4:0] r;
        r = 5'h00;
        if (sync) begin
            if (code == MRAT_SYNC_1) r = 5'h01; // see RQ10
        end else begin
            case (code) // async codes name their own ratio, so the code passes through
                5'h05, 5'h06, 5'h08, 5'h09, 5'h0a: r = code; // see RQ8
                5'h0c, 5'h0d, 5'h10, 5'h12, 5'h13, 5'h14, 5'h18: r = code; // see RQ9
                default: r = 5'h00;
            endcase
        end
        return r;
    endfunction : mem_ratio_of

    // ==========================================================
    // combinational decode
    // ==========================================================
    pll_src_t src0_c, src1_c;   // per-cluster decode
    logic [1:0] div0_c, div1_c;
    logic rsv0_c, rsv1_c;
    logic sync_c;               // memory synchronous select
    logic [4:0] ratio_c;        // numeric memory ratio
    logic err_c;                // any reserved code

    // two independent decoders, one per cluster
    core_sel_decode u_dec0 ( // see RQ2
        .i_code(i_core_cluster_pll_select0),
        .o_src(src0_c),
        .o_div(div0_c),
        .o_reserved(rsv0_c)
    );
    core_sel_decode u_dec1 (
        .i_code(i_core_cluster_pll_select1),
        .o_src(src1_c),
        .o_div(div1_c),
        .o_reserved(rsv1_c)
    );

    assign sync_c = i_reset_config_word[POS_MEM_SYNC]; // see RQ5
    assign ratio_c = mem_ratio_of(sync_c, i_reset_config_word[POS_MEM_RATIO_LO +: 5]);
    // reserved codes in any of the three fields (cluster 0, cluster 1, memory ratio) flag an error
    assign err_c = rsv0_c | rsv1_c | (ratio_c == 5'h00); // see RQ15

    // ==========================================================
    // held selections
    // ==========================================================
    logic ctrl_en_q;   // software gate on capture of new selections
    logic loaded_q;    // a configuration has been captured
    logic err_q;       // config error of the last accepted load

    // capture on load strobe, held static afterwards
    always_ff @(posedge i_clk or negedge i_nrst) begin
        if (!i_nrst) begin
            o_core0_src <= SRC_NONE;
            o_core0_div <= 2'h0;
            o_core1_src <= SRC_NONE;
            o_core1_div <= 2'h0;
            o_mem_ref <= REF_SYSTEM;
            o_mem_ratio <= 5'h00;
            o_mem_range <= 2'h0;
            loaded_q <= 1'b0;
        end else if (i_ce && i_cfg_load && ctrl_en_q) begin
            o_core0_src <= src0_c; // see RQ1
            o_core0_div <= div0_c;
            o_core1_src <= src1_c;
            o_core1_div <= div1_c;
            // single reference and ratio shared by both controllers
            o_mem_ref <= sync_c ? REF_PLATFORM : REF_SYSTEM; // see RQ14 see RQ4
            o_mem_ratio <= ratio_c;
            // sync mode uses the high-platform range; async range is given by the configurer
            o_mem_range <= sync_c ? RANGE_HI_PLAT : i_mem_pll_range; // see RQ10
            loaded_q <= 1'b1;
        end
    end

    // error flag follows each load, set on reserved codes
    always_ff @(posedge i_clk or negedge i_nrst) begin
        if (!i_nrst) begin
            err_q <= 1'b0;
        end else if (i_ce && i_cfg_load && ctrl_en_q) begin
            err_q <= err_c; // see RQ15
        end
    end
    assign o_cfg_error = err_q;

    // ==========================================================
    // axi4-lite write
    // ==========================================================
    logic aw_hold_q, w_hold_q;  // channel taken, waiting for partner
    logic [5:0] awaddr_q;
    logic [31:0] wdata_q;
    logic [3:0] wstrb_q;
    logic bvalid_q;
    logic [1:0] bresp_q;

    assign o_awready = !aw_hold_q && !bvalid_q;
    assign o_wready = !w_hold_q && !bvalid_q;
    assign o_bvalid = bvalid_q;
    assign o_bresp = bresp_q;

    // address and data may arrive in either order
    always_ff @(posedge i_clk or negedge i_nrst) begin
        if (!i_nrst) begin
            aw_hold_q <= 1'b0;
            w_hold_q <= 1'b0;
            awaddr_q <= 6'h00;
            wdata_q <= 32'h0;
            wstrb_q <= 4'h0;
            bvalid_q <= 1'b0;
            bresp_q <= 2'h0;
        end else if (i_ce) begin
            if (i_awvalid && o_awready) begin
                aw_hold_q <= 1'b1;
                awaddr_q <= i_awaddr;
            end
            if (i_wvalid && o_wready) begin
                w_hold_q <= 1'b1;
                wdata_q <= i_wdata;
                wstrb_q <= i_wstrb;
            end
            if (aw_hold_q && w_hold_q) begin
                aw_hold_q <= 1'b0;
                w_hold_q <= 1'b0;
                bvalid_q <= 1'b1;
                // only the control word is writable
                bresp_q <= (awaddr_q[5:2] == ADDR_CTRL[5:2]) ? 2'h0 : 2'h2;
            end else if (bvalid_q && i_bready) begin
                bvalid_q <= 1'b0;
            end
        end
    end

    // control register; gates capture of new selections
    always_ff @(posedge i_clk or negedge i_nrst) begin
        if (!i_nrst) begin
            ctrl_en_q <= CTRL_RESET[0];
        end else if (i_ce && aw_hold_q && w_hold_q && awaddr_q[5:2] == ADDR_CTRL[5:2] && wstrb_q[0]) begin
            ctrl_en_q <= wdata_q[0];
        end
    end

    // ==========================================================
    // axi4-lite read
    // ==========================================================
    logic rvalid_q;
    assign o_arready = !rvalid_q;
    assign o_rvalid = rvalid_q;

    // one-cycle answer; unmapped reads return slverr
    always_ff @(posedge i_clk or negedge i_nrst) begin
        if (!i_nrst) begin
            rvalid_q <= 1'b0;
            o_rdata <= 32'h0;
            o_rresp <= 2'h0;
        end else if (i_ce) begin
            if (i_arvalid && o_arready) begin
                rvalid_q <= 1'b1;
                o_rresp <= 2'h0;
                if (i_araddr[5:2] == ADDR_CTRL[5:2]) begin
                    o_rdata <= {31'h0, ctrl_en_q};
                end else if (i_araddr[5:2] == ADDR_CORE[5:2]) begin
                    o_rdata <= {24'h0, o_core1_src, o_core1_div, o_core0_src, o_core0_div};
                end else if (i_araddr[5:2] == ADDR_MEM[5:2]) begin
                    o_rdata <= {24'h0, o_mem_range, o_mem_ref, o_mem_ratio};
                end else if (i_araddr[5:2] == ADDR_STATUS[5:2]) begin
                    o_rdata <= {30'h0, loaded_q, err_q};
                end else begin
                    o_rdata <= 32'h0;
                    o_rresp <= 2'h2;
                end
            end else if (rvalid_q && i_rready) begin
                rvalid_q <= 1'b0;
            end
        end
    end

    // ==========================================================
    // assertions
    // ==========================================================
    property p_ref_follows_sync;
        @(posedge i_clk) disable iff (!i_nrst)
        (i_ce && i_cfg_load && ctrl_en_q) |=> (o_mem_ref == ($past(sync_c) ? REF_PLATFORM : REF_SYSTEM));
    endproperty
    a_ref_follows_sync: assert property (p_ref_follows_sync) else $error("memory reference wrong"); // see RQ14

    property p_sync_ratio;
        @(posedge i_clk) disable iff (!i_nrst)
        (loaded_q && o_mem_ref == REF_PLATFORM && !o_cfg_error) |-> (o_mem_ratio == 5'h01 && o_mem_range == 2'h1);
    endproperty
    a_sync_ratio: assert property (p_sync_ratio) else $error("sync ratio not 1:1"); // see RQ10

    property p_core0_second;
        @(posedge i_clk) disable iff (!i_nrst)
        (i_ce && i_cfg_load && ctrl_en_q && i_core_cluster_pll_select0 == 4'h5)
        |=> (o_core0_src == SRC_SECOND && o_core0_div == 2'h2);
    endproperty
    a_core0_second: assert property (p_core0_second) else $error("cluster 0 decode wrong"); // see RQ1

    property p_core1_indep;
        @(posedge i_clk) disable iff (!i_nrst)
        (i_ce && i_cfg_load && ctrl_en_q && i_core_cluster_pll_select1 == 4'h0)
        |=> (o_core1_src == SRC_FIRST && o_core1_div == 2'h1);
    endproperty
    a_core1_indep: assert property (p_core1_indep) else $error("cluster 1 decode wrong"); // see RQ2

    property p_err_reserved;
        @(posedge i_clk) disable iff (!i_nrst)
        (i_ce && i_cfg_load && ctrl_en_q && i_core_cluster_pll_select0 == 4'h2) |=> o_cfg_error;
    endproperty
    a_err_reserved: assert property (p_err_reserved) else $error("reserved code not flagged"); // see RQ15

    property p_async_ratio;
        @(posedge i_clk) disable iff (!i_nrst)
        (loaded_q && o_mem_ref == REF_SYSTEM && o_mem_ratio != 5'h00) |-> (o_mem_ratio >= 5'h05);
    endproperty
    a_async_ratio: assert property (p_async_ratio) else $error("async ratio out of set"); // see RQ8

    property p_ratio24;
        @(posedge i_clk) disable iff (!i_nrst)
        (i_ce && i_cfg_load && ctrl_en_q && !sync_c && i_reset_config_word[POS_MEM_RATIO_LO +: 5] == 5'h18)
        |=> (o_mem_ratio == 5'h18 && o_mem_ref == REF_SYSTEM);
    endproperty
    a_ratio24: assert property (p_ratio24) else $error("ratio 24 not decoded"); // see RQ9

    property p_held;
        @(posedge i_clk) disable iff (!i_nrst)
        (!i_cfg_load) |=> $stable(o_mem_ratio) && $stable(o_core0_src) && $stable(o_mem_ref);
    endproperty
    a_held: assert property (p_held) else $error("selection changed without load"); // see RQ4

    c_load: cover property (@(posedge i_clk) disable iff (!i_nrst) i_cfg_load ##1 loaded_q);
    c_sync: cover property (@(posedge i_clk) disable iff (!i_nrst) o_mem_ref == REF_PLATFORM);
    c_err: cover property (@(posedge i_clk) disable iff (!i_nrst) o_cfg_error);
endmodule : clk_ratio_decoder

// [dv/tb_top.sv]
// self-checking testbench for the core and memory pll ratio decoder
`timescale 1ns/1ps
module tb_top
    import clk_ratio_pkg::*;
;
    // ==========================================================
    // stimulus and observed signals
    // ==========================================================
    logic i_clk, i_nrst, i_ce, i_cfg_load, i_awvalid, i_wvalid, i_bready, i_arvalid, i_rready;
    logic [511:0] i_reset_config_word;  // sampled configuration word
    logic [3:0] i_core_cluster_pll_select0, i_core_cluster_pll_select1, i_wstrb;
    logic [1:0] i_mem_pll_range;
    logic [5:0] i_awaddr, i_araddr;
    logic [31:0] i_wdata;
    logic o_awready, o_wready, o_bvalid, o_arready, o_rvalid, o_cfg_error;
    logic [1:0] o_bresp, o_rresp, o_core0_div, o_core1_div, o_mem_range;
    logic [31:0] o_rdata;
    logic [4:0] o_mem_ratio;
    pll_src_t o_core0_src, o_core1_src;
    mem_ref_t o_mem_ref;
    int n_fail = 0;        // mismatches seen
    int checks_done = 0;   // comparisons made
    int cyc = 0;           // cycles since start, for the hang guard
    logic [31:0] rd;
    logic [1:0] rs;

    clk_ratio_decoder #(.CW_BITS(512)) dut (
        .i_clk(i_clk), .i_nrst(i_nrst), .i_ce(i_ce), .i_reset_config_word(i_reset_config_word),
        .i_core_cluster_pll_select0(i_core_cluster_pll_select0),
        .i_core_cluster_pll_select1(i_core_cluster_pll_select1),
        .i_mem_pll_range(i_mem_pll_range), .i_cfg_load(i_cfg_load),
        .i_awaddr(i_awaddr), .i_awvalid(i_awvalid), .o_awready(o_awready), .i_wdata(i_wdata),
        .i_wstrb(i_wstrb), .i_wvalid(i_wvalid), .o_wready(o_wready), .o_bresp(o_bresp),
        .o_bvalid(o_bvalid), .i_bready(i_bready), .i_araddr(i_araddr), .i_arvalid(i_arvalid),
        .o_arready(o_arready), .o_rdata(o_rdata), .o_rresp(o_rresp), .o_rvalid(o_rvalid),
        .i_rready(i_rready), .o_core0_src(o_core0_src), .o_core0_div(o_core0_div),
        .o_core1_src(o_core1_src), .o_core1_div(o_core1_div), .o_mem_ref(o_mem_ref),
        .o_mem_ratio(o_mem_ratio), .o_mem_range(o_mem_range), .o_cfg_error(o_cfg_error)
    );

    // ==========================================================
    // clock and hang guard
    // ==========================================================
    // 100 mhz free-running clock
    initial begin
        i_clk = 1'h0;
        forever #5 i_clk = ~i_clk;
    end
    // a few hundred cycles are needed, so 5000 means something is stuck
    always @(posedge i_clk) begin
        cyc <= cyc + 1;
        if (cyc == 5000) begin
            n_fail++;
            close_out();
        end
    end

    // ==========================================================
    // shared tasks and reference functions
    // ==========================================================
    // compare one value, count it, report a mismatch at once
    task automatic chk(input logic [31:0] got, input logic [31:0] exp, input string what);
        checks_done++;
        if (got !== exp) begin
            n_fail++;
            $display("[FAIL] %0t %s got %h exp %h", $time, what, got, exp);
        end
    endtask : chk
    // one write: address and data offered together, each dropped when taken
    task automatic axi_wr(input logic [5:0] a, input logic [31:0] d, output logic [1:0] resp);
        @(posedge i_clk);
        i_awaddr <= a;
        i_wdata <= d;
        i_awvalid <= 1'h1;
        i_wvalid <= 1'h1;
        i_bready <= 1'h1;
        forever begin
            @(posedge i_clk);
            if (i_awvalid && o_awready) i_awvalid <= 1'h0;
            if (i_wvalid && o_wready) i_wvalid <= 1'h0;
            if (i_bready && o_bvalid) begin
                resp = o_bresp;
                i_bready <= 1'h0;
                break;
            end
        end
    endtask : axi_wr
    // one read: rready held until the data beat is sampled
    task automatic axi_rd(input logic [5:0] a, output logic [31:0] d, output logic [1:0] resp);
        @(posedge i_clk);
        i_araddr <= a;
        i_arvalid <= 1'h1;
        i_rready <= 1'h1;
        forever begin
            @(posedge i_clk);
            if (i_arvalid && o_arready) i_arvalid <= 1'h0;
            if (i_rready && o_rvalid) begin
                d = o_rdata;
                resp = o_rresp;
                i_rready <= 1'h0;
                break;
            end
        end
    endtask : axi_rd
    // {error, source, divider} expected for one cluster select code
    function automatic logic [4:0] core_exp(input logic [3:0] c);
        case (c)
            CSEL_P1_D1: return 5'h05;
            CSEL_P1_D2: return 5'h06;
            CSEL_P2_D1: return 5'h09;
            CSEL_P2_D2: return 5'h0a;
            default: return 5'h10;
        endcase
    endfunction : core_exp
    // {error, ratio}: async ratio codes equal the ratio they name
    function automatic logic [5:0] mem_exp(input logic sy, input logic [4:0] c);
        if (sy) return (c == MRAT_SYNC_1) ? 6'h01 : 6'h20;
        case (c)
            5'h05, 5'h06, 5'h08, 5'h09, 5'h0a, 5'h0c, 5'h0d, 5'h10, 5'h12, 5'h13, 5'h14, 5'h18: return {1'h0, c};
            default: return 6'h20;
        endcase
    endfunction : mem_exp
    // present one configuration with a load strobe, settle past the update edge
    task automatic load(input logic [3:0] c0, input logic [3:0] c1, input logic sy, input logic [4:0] rt,
                        input logic [1:0] rg);
        logic [511:0] w;
        w = '0;
        w[POS_MEM_RATIO_LO +: 5] = rt;
        w[POS_MEM_SYNC] = sy;
        w[POS_MEM_RATE] = sy;   // rate bit follows sync bit
        w[POS_MEM_RSV0] = 1'h0; // reserved memory bit kept clear
        @(posedge i_clk);
        i_reset_config_word <= w;
        i_core_cluster_pll_select0 <= c0;
        i_core_cluster_pll_select1 <= c1;
        i_mem_pll_range <= rg;
        i_cfg_load <= 1'h1;
        @(posedge i_clk);
        i_cfg_load <= 1'h0;
        @(negedge i_clk);
    endtask : load
    // judge every decoded output against the reference for one load
    task automatic chk_cfg(input logic [3:0] c0, input logic [3:0] c1, input logic sy, input logic [4:0] rt,
                           input logic [1:0] rg);
        logic [4:0] e0, e1;
        logic [5:0] em;
        e0 = core_exp(c0);
        e1 = core_exp(c1);
        em = mem_exp(sy, rt);
        chk(32'({o_core0_src, o_core0_div}), 32'(e0[3:0]), "core0 sel");
        chk(32'({o_core1_src, o_core1_div}), 32'(e1[3:0]), "core1 sel");
        chk(32'(o_mem_ratio), 32'(em[4:0]), "mem ratio");
        chk(32'(o_mem_ref), 32'(sy), "mem ref");
        chk(32'(o_mem_range), sy ? 32'(RANGE_HI_PLAT) : 32'(rg), "mem range");
        chk(32'(o_cfg_error), 32'(e0[4] | e1[4] | em[5]), "cfg error");
    endtask : chk_cfg

    // ==========================================================
    // scenarios
    // ==========================================================
    // memory ratio idle after reset, load enable reads back set
    task automatic t_reset;
        chk(32'(o_mem_ratio), 32'h0, "reset ratio");
        axi_rd(ADDR_CTRL, rd, rs);
        chk(rd, CTRL_RESET, "ctrl reset");
        chk(32'(rs), 32'h0, "ctrl resp");
    endtask : t_reset
    // all sixteen codes on cluster 0 with the mirror code on cluster 1
    task automatic t_core;
        for (int i = 0; i < 16; i++) begin
            // ratio 8 with range 10 stands for a reference below the 120.9 mhz limit
            load(4'(i), 4'(15 - i), 1'h0, 5'h08, 2'h2);
            chk_cfg(4'(i), 4'(15 - i), 1'h0, 5'h08, 2'h2);
        end
        // second cluster pll taken as slower than the first
        load(CSEL_P2_D2, CSEL_P2_D1, 1'h0, 5'h0a, 2'h1);
        axi_rd(ADDR_CORE, rd, rs);
        chk(rd, 32'h9a, "core readback");
    endtask : t_core
    // every ratio code in both memory modes
    task automatic t_mem;
        for (int s = 0; s < 2; s++) begin
            for (int c = 0; c < 32; c++) begin
                // ratio 6 assumes a reference no faster than 161.2 mhz
                load(CSEL_P1_D1, CSEL_P1_D2, 1'(s), 5'(c), 2'(c));
                chk_cfg(CSEL_P1_D1, CSEL_P1_D2, 1'(s), 5'(c), 2'(c));
            end
        end
        axi_rd(ADDR_MEM, rd, rs);
        chk(rd, 32'h60, "mem readback");
        axi_rd(ADDR_STATUS, rd, rs);
        chk(rd, 32'h3, "status");
    endtask : t_mem
    // error responses, then loads refused while disabled
    task automatic t_regs;
        axi_wr(ADDR_CORE, 32'h0, rs);
        chk(32'(rs), 32'h2, "ro write resp");
        axi_rd(6'h1c, rd, rs);
        chk(rd, 32'h0, "unmapped data");
        chk(32'(rs), 32'h2, "unmapped resp");
        axi_wr(ADDR_CTRL, 32'h0, rs);
        chk(32'(rs), 32'h0, "ctrl wr resp");
        load(CSEL_P2_D1, CSEL_P2_D1, 1'h0, 5'h05, 2'h0);
        // the last accepted load still stands
        chk_cfg(CSEL_P1_D1, CSEL_P1_D2, 1'h1, 5'h1f, 2'h3);
        axi_wr(ADDR_CTRL, 32'h1, rs);
        load(CSEL_P2_D1, CSEL_P1_D2, 1'h1, MRAT_SYNC_1, 2'h2);
        chk_cfg(CSEL_P2_D1, CSEL_P1_D2, 1'h1, MRAT_SYNC_1, 2'h2);
        // clock enable low: a load strobe must leave every selection alone
        @(posedge i_clk);
        i_ce <= 1'h0;
        load(CSEL_P1_D1, CSEL_P1_D1, 1'h0, 5'h05, 2'h0);
        chk_cfg(CSEL_P2_D1, CSEL_P1_D2, 1'h1, MRAT_SYNC_1, 2'h2);
        @(posedge i_clk);
        i_ce <= 1'h1;
        // mid-run reset clears the selections and re-enables loads
        axi_wr(ADDR_CTRL, 32'h0, rs);
        @(posedge i_clk);
        i_nrst <= 1'h0;
        @(negedge i_clk);
        chk(32'({o_core0_src, o_core1_src, o_mem_ratio}), 32'h0, "reset sel");
        chk(32'({o_mem_ref, o_mem_range, o_cfg_error}), 32'h0, "reset mem");
        repeat (2) @(posedge i_clk);
        i_nrst <= 1'h1;
        @(negedge i_clk);
        axi_rd(ADDR_CTRL, rd, rs);
        chk(rd, CTRL_RESET, "ctrl after reset");
        load(CSEL_P1_D2, CSEL_P2_D2, 1'h0, 5'h0c, 2'h3);
        chk_cfg(CSEL_P1_D2, CSEL_P2_D2, 1'h0, 5'h0c, 2'h3);
    endtask : t_regs

    // ==========================================================
    // verdict and main sequence
    // ==========================================================
    task automatic close_out;
        $display("checks %0d mismatches %0d", checks_done, n_fail);
        if (n_fail == 0 && checks_done > 0) begin
            $display("verification passed");
        end else begin
            $display("verification failed");
        end
        $finish;
    endtask : close_out
    // everything starts defined; clock enable starts high and write strobes stay tied high
    initial begin
        {i_nrst, i_cfg_load, i_awvalid, i_wvalid, i_bready, i_arvalid, i_rready} = '0;
        i_ce = 1'h1;
        i_wstrb = 4'hf;
        i_reset_config_word = '0;
        i_core_cluster_pll_select0 = 4'h0;
        i_core_cluster_pll_select1 = 4'h0;
        i_mem_pll_range = 2'h0;
        i_awaddr = 6'h0;
        i_araddr = 6'h0;
        i_wdata = 32'h0;
        repeat (20) @(posedge i_clk);
        i_nrst <= 1'h1;
        @(negedge i_clk);
        t_reset();
        t_core();
        t_mem();
        t_regs();
        close_out();
    end
endmodule : tb_top
